/* File: core/p4cs_pkg.sv */
// Package: register map, field layout and types of the port four strobe decoder
package p4cs_pkg;

  // ****************************************
  // Register offsets on the special function bus
  // ****************************************
  localparam logic [7:0] P4CS_OFS_POLARITY = 8'hae;
  localparam logic [7:0] P4CS_OFS_CONFIG_A = 8'hc2;
  localparam logic [7:0] P4CS_OFS_CONFIG_B = 8'hc3;
  localparam logic [7:0] P4CS_OFS_DATA     = 8'hd8;
  localparam logic [7:0] P4CS_OFS_CS0_LOW  = 8'h84;
  localparam logic [7:0] P4CS_OFS_CS0_HIGH = 8'h85;
  localparam logic [7:0] P4CS_OFS_CS1_LOW  = 8'h94;
  localparam logic [7:0] P4CS_OFS_CS1_HIGH = 8'h95;
  localparam logic [7:0] P4CS_OFS_CS2_LOW  = 8'ha4;
  localparam logic [7:0] P4CS_OFS_CS2_HIGH = 8'ha5;
  localparam logic [7:0] P4CS_OFS_CS3_LOW  = 8'ha6;
  localparam logic [7:0] P4CS_OFS_CS3_HIGH = 8'ha7;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [7:0] P4CS_RST_BYTE     = 8'h00;
  localparam logic [7:0] P4CS_RST_DATA     = 8'hff;
  localparam int         P4CS_POL_LSB      = 4;
  localparam logic [7:0] P4CS_POL_WR_MASK  = 8'hfc;
  localparam logic [7:0] P4CS_UNMAPPED     = 8'hff;

  // ****************************************
  // Pin function and compare length encodings
  // ****************************************
  typedef enum logic [1:0] {
    P4CS_FN_GPIO   = 2'h0,
    P4CS_FN_RD     = 2'h1,
    P4CS_FN_WR     = 2'h2,
    P4CS_FN_RDWR   = 2'h3
  } p4cs_func_t;

  typedef enum logic [1:0] {
    P4CS_CMP_FULL  = 2'h0,
    P4CS_CMP_A15_1 = 2'h1,
    P4CS_CMP_A15_2 = 2'h2,
    P4CS_CMP_A15_8 = 2'h3
  } p4cs_cmp_t;

  localparam logic [15:0] P4CS_MASK_FULL  = 16'hffff;
  localparam logic [15:0] P4CS_MASK_A15_1 = 16'hfffe;
  localparam logic [15:0] P4CS_MASK_A15_2 = 16'hfffc;
  localparam logic [15:0] P4CS_MASK_A15_8 = 16'hff00;

  // One configuration nibble: function in the upper pair, length in the lower
  typedef struct packed {
    p4cs_func_t func;
    p4cs_cmp_t  cmp;
  } p4cs_pin_cfg_t;

  // External bus cycle as seen by the decoder
  typedef struct packed {
    logic [15:0] addr;
    logic        rd_n;
    logic        wr_n;
  } p4cs_xbus_t;

endpackage

/* File: core/p4cs_base_mem.sv */
// Base address store: four 16-bit bases written a byte at a time, registered read
module p4cs_base_mem
  import p4cs_pkg::*;
#(
  parameter int N_PINS = 4
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      arst_n_i,
  input  wire logic                      wr_en_i,
  input  wire logic [1:0]                wr_pin_i,
  input  wire logic                      wr_high_i,
  input  wire logic [7:0]                wr_data_i,
  input  wire logic [1:0]                rd_pin_i,
  input  wire logic                      rd_high_i,
  output logic      [7:0]                rd_data_o,
  output logic      [N_PINS-1:0][15:0]   base_o
);

  logic [N_PINS-1:0][15:0] base_ff;

  // ****************************************
  // Storage, one entry per pin
  // ****************************************
  for (genvar p = 0; p < N_PINS; p++) begin : g_entry
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        base_ff[p] <= {P4CS_RST_BYTE, P4CS_RST_BYTE};
      end else if (wr_en_i && (wr_pin_i == 2'(p))) begin
        if (wr_high_i) begin
          base_ff[p][15:8] <= wr_data_i; // see [R13]
        end else begin
          base_ff[p][7:0] <= wr_data_i; // see [R13]
        end
      end
    end
  end

  // ****************************************
  // Registered read port
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o <= P4CS_RST_BYTE;
    end else begin
      rd_data_o <= rd_high_i ? base_ff[rd_pin_i][15:8] : base_ff[rd_pin_i][7:0];
    end
  end

  assign base_o = base_ff;

endmodule

/* File: core/p4cs_port.sv */
// Port four: general I/O and address decoded chip select strobes
// ****************************************
// Functional notes
// ****************************************
//
// Functional notes
// [R1] Length 00 compares all sixteen address bits with the base.
// [R2] Length 01 compares address bits 15 to 1, ignores bit 0.
// [R3] Length 10 compares address bits 15 to 2, ignores bits 1 and 0.
// [R4] Length 11 compares only the upper address byte.
// [R5] Config B bits 3:2 select pin 2 function.
// [R6] Config B bits 1:0 set pin 2 compare length.
// [R7] Config A bits 7:6 select pin 1 function.
// [R8] Config A bits 5:4 set pin 1 compare length.
// [R9] Config A bits 3:2 select pin 0 function.
// [R10] Config A bits 1:0 set pin 0 compare length.
// [R11] Polarity bit 7 makes pin 3 strobe active high when set.
// [R12] Polarity bits 6,5,4 set strobe level for pins 2,1,0.
// [R13] Each pin has its own 16-bit base, high and low byte.
// [R14] Data bits 3:0 drive pins 3:0 only in general I/O mode.
// [R15] Matching external write yields write strobe at chosen polarity.
// [R16] Function 00 I/O, 01 read, 10 write, 11 read or write strobe.
// [R17] Strobe coincides with bus read, write or either on a match.
// [R18] Strobe pins ignore data bits and idle at inactive level.
module p4cs_port
  import p4cs_pkg::*;
#(
  parameter int N_PINS = 4
) (
  input  wire logic                ref_clk_i,
  input  wire logic                arst_n_i,
  input  wire logic                sfr_wr_i,
  input  wire logic                sfr_rd_i,
  input  wire logic [7:0]          sfr_addr_i,
  input  wire logic [7:0]          sfr_wdata_i,
  output logic      [7:0]          sfr_rdata_o,
  input  wire logic [15:0]         xbus_addr_i,
  input  wire logic                xbus_rd_n_i,
  input  wire logic                xbus_wr_n_i,
  input  wire logic [7:0]          pin_i,
  output logic      [7:0]          pin_o,
  output logic      [7:0]          pin_oe_o
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]                 cfg_a_ff;
  logic [7:0]                 cfg_b_ff;
  logic [7:0]                 polarity_ff;
  logic [7:0]                 data_ff;
  logic [7:0]                 pin_sync1_ff;
  logic [7:0]                 pin_sync2_ff;
  logic [7:0]                 rdata_ff;
  logic                       base_rd_ff;
  logic [7:0]                 base_rdata;
  logic [N_PINS-1:0][15:0]    base;
  logic [N_PINS-1:0]          strobe_on;
  logic [N_PINS-1:0]          strobe_mode;
  logic [N_PINS-1:0]          pin_lvl;
  p4cs_pin_cfg_t [N_PINS-1:0] pin_cfg;
  p4cs_xbus_t                 xbus;
  logic                       base_sel;
  logic [1:0]                 base_pin;
  logic                       base_high;
  logic [7:0]                 nxt_rdata;

  assign xbus = '{addr: xbus_addr_i, rd_n: xbus_rd_n_i, wr_n: xbus_wr_n_i};

  // Base register address decode
  always_comb begin
    base_sel  = 1'b1;
    base_pin  = 2'h0;
    base_high = 1'b0;
    case (sfr_addr_i)
      P4CS_OFS_CS0_LOW: begin
        base_pin = 2'h0;
      end
      P4CS_OFS_CS0_HIGH: begin
        base_pin  = 2'h0;
        base_high = 1'b1;
      end
      P4CS_OFS_CS1_LOW: begin
        base_pin = 2'h1;
      end
      P4CS_OFS_CS1_HIGH: begin
        base_pin  = 2'h1;
        base_high = 1'b1;
      end
      P4CS_OFS_CS2_LOW: begin
        base_pin = 2'h2;
      end
      P4CS_OFS_CS2_HIGH: begin
        base_pin  = 2'h2;
        base_high = 1'b1;
      end
      P4CS_OFS_CS3_LOW: begin
        base_pin = 2'h3;
      end
      P4CS_OFS_CS3_HIGH: begin
        base_pin  = 2'h3;
        base_high = 1'b1;
      end
      default: begin
        base_sel = 1'b0;
      end
    endcase
  end

  p4cs_base_mem #(
    .N_PINS (N_PINS)
  ) u_base (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .wr_en_i   (sfr_wr_i && base_sel),
    .wr_pin_i  (base_pin),
    .wr_high_i (base_high),
    .wr_data_i (sfr_wdata_i),
    .rd_pin_i  (base_pin),
    .rd_high_i (base_high),
    .rd_data_o (base_rdata),
    .base_o    (base)
  );

  // ****************************************
  // Configuration writes
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_a_ff <= P4CS_RST_BYTE;
    end else if (sfr_wr_i && sfr_addr_i == P4CS_OFS_CONFIG_A) begin
      cfg_a_ff <= sfr_wdata_i; // see [R7] see [R8] see [R9] see [R10]
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_b_ff <= P4CS_RST_BYTE;
    end else if (sfr_wr_i && sfr_addr_i == P4CS_OFS_CONFIG_B) begin
      cfg_b_ff <= sfr_wdata_i; // see [R5] see [R6]
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      polarity_ff <= P4CS_RST_BYTE;
    end else if (sfr_wr_i && sfr_addr_i == P4CS_OFS_POLARITY) begin
      polarity_ff <= sfr_wdata_i & P4CS_POL_WR_MASK; // see [R11] see [R12]
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_ff <= P4CS_RST_DATA;
    end else if (sfr_wr_i && sfr_addr_i == P4CS_OFS_DATA) begin
      data_ff <= sfr_wdata_i;
    end
  end

  // Pin input synchroniser
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_sync1_ff <= P4CS_RST_BYTE;
      pin_sync2_ff <= P4CS_RST_BYTE;
    end else begin
      pin_sync1_ff <= pin_i;
      pin_sync2_ff <= pin_sync1_ff;
    end
  end

  // ****************************************
  // Register read back
  // ****************************************
  always_comb begin
    case (sfr_addr_i)
      P4CS_OFS_POLARITY: nxt_rdata = polarity_ff;
      P4CS_OFS_CONFIG_A: nxt_rdata = cfg_a_ff;
      P4CS_OFS_CONFIG_B: nxt_rdata = cfg_b_ff;
      P4CS_OFS_DATA:     nxt_rdata = pin_sync2_ff;
      default:           nxt_rdata = P4CS_UNMAPPED;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_ff   <= P4CS_RST_BYTE;
      base_rd_ff <= 1'b0;
    end else if (sfr_rd_i) begin
      rdata_ff   <= nxt_rdata;
      base_rd_ff <= base_sel;
    end
  end

  assign sfr_rdata_o = base_rd_ff ? base_rdata : rdata_ff;

  // ****************************************
  // Decoders, one per strobe capable pin
  // ****************************************
  assign pin_cfg = {cfg_b_ff, cfg_a_ff};

  for (genvar p = 0; p < N_PINS; p++) begin : g_pin
    logic [15:0] mask;
    logic        hit;
    logic        qual;

    always_comb begin
      case (pin_cfg[p].cmp)
        P4CS_CMP_FULL:  mask = P4CS_MASK_FULL;  // see [R1]
        P4CS_CMP_A15_1: mask = P4CS_MASK_A15_1; // see [R2]
        P4CS_CMP_A15_2: mask = P4CS_MASK_A15_2; // see [R3]
        P4CS_CMP_A15_8: mask = P4CS_MASK_A15_8; // see [R4]
        default:        mask = P4CS_MASK_FULL;
      endcase
    end

    assign hit = ((xbus.addr ^ base[p]) & mask) == 16'h0000;

    always_comb begin
      case (pin_cfg[p].func)
        P4CS_FN_RD:   qual = !xbus.rd_n;                 // see [R16] see [R17]
        P4CS_FN_WR:   qual = !xbus.wr_n;                 // see [R15] see [R16]
        P4CS_FN_RDWR: qual = !xbus.rd_n || !xbus.wr_n;   // see [R17]
        default:      qual = 1'b0;
      endcase
    end

    assign strobe_mode[p] = pin_cfg[p].func != P4CS_FN_GPIO;
    assign strobe_on[p]   = hit && qual;
    // Strobe level per polarity bit, data bit only in I/O mode
    assign pin_lvl[p] = strobe_mode[p]
                      ? (strobe_on[p] ~^ polarity_ff[P4CS_POL_LSB + p]) // see [R11] see [R12] see [R18]
                      : data_ff[p];                                      // see [R14]
  end

  // ****************************************
  // Pin drivers: quasi bidirectional in I/O mode
  // ****************************************
  assign pin_o    = {data_ff[7:N_PINS], pin_lvl};
  assign pin_oe_o = {~data_ff[7:N_PINS], strobe_mode | ~data_ff[N_PINS-1:0]};

  // ****************************************
  // Checks
  // ****************************************
  chk_wr_strobe_level: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (pin_cfg[0].func == P4CS_FN_WR && !xbus.wr_n && ((xbus.addr ^ base[0]) & P4CS_MASK_A15_8) == 0
     && pin_cfg[0].cmp == P4CS_CMP_A15_8) |-> pin_o[0] == polarity_ff[4]) // see [R15]
    else $error("pin 0 write strobe wrong");
  chk_full_compare: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (pin_cfg[1].cmp == P4CS_CMP_FULL && xbus.addr != base[1] && strobe_mode[1])
    |-> pin_o[1] == !polarity_ff[5]) // see [R1]
    else $error("pin 1 strobe on mismatch");
  chk_bit0_ignored: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (pin_cfg[2].cmp == P4CS_CMP_A15_1 && xbus.addr == (base[2] ^ 16'h0001)
     && pin_cfg[2].func == P4CS_FN_RDWR && !xbus.rd_n) |-> pin_o[2] == polarity_ff[6]) // see [R2]
    else $error("pin 2 bit zero not ignored");
  chk_low_two_ignored: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (pin_cfg[3].cmp == P4CS_CMP_A15_2 && xbus.addr == (base[3] ^ 16'h0003)
     && pin_cfg[3].func == P4CS_FN_RD && !xbus.rd_n) |-> pin_o[3] == polarity_ff[7]) // see [R3]
    else $error("pin 3 low bits not ignored");
  chk_rd_not_wr: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (pin_cfg[0].func == P4CS_FN_RD && xbus.rd_n) |-> pin_o[0] == !polarity_ff[4]) // see [R17]
    else $error("read strobe without read");
  chk_gpio_data: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (pin_cfg[1].func == P4CS_FN_GPIO) |-> pin_o[1] == data_ff[1]) // see [R14]
    else $error("I/O pin ignores data");
  chk_strobe_drive: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    strobe_mode[3] |-> pin_oe_o[3]) // see [R18]
    else $error("strobe pin not driven");
  chk_cfg_write: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (sfr_wr_i && sfr_addr_i == P4CS_OFS_CONFIG_B) |=> pin_cfg[2] == $past(sfr_wdata_i[3:0])) // see [R5]
    else $error("config B not applied");
  cov_wr_strobe: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    strobe_on[0] && pin_cfg[0].func == P4CS_FN_WR);
  cov_rd_strobe: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    strobe_on[3] && pin_cfg[3].func == P4CS_FN_RD);
  cov_high_pol: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    strobe_on[1] && polarity_ff[5]);

endmodule

/* File: verification/p4cs_xperiph.sv */
// Far-side model: peripherals on the port four pins, with pull-ups
module p4cs_xperiph (
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] pin_oe_i,
  output logic      [7:0] pin_level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // *****
  // Wire level
  // *****
  // Released pins float up through the pull-up
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      pin_level_o[b] = pin_oe_i[b] ? pin_o_i[b] : 1'b1;
    end
  end
endmodule

/* File: verification/p4cs_port_tb.sv */
// Testbench: port four registers, general I/O and chip select decoding
module p4cs_port_tb
  import p4cs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // *****
  // Stimulus and observed signals
  // *****
  logic        ref_clk   = 1'b0;
  logic        arst_n    = 1'b0;
  logic        sfr_wr    = 1'b0;
  logic        sfr_rd    = 1'b0;
  logic [7:0]  sfr_addr  = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [15:0] xaddr     = 16'h0000;
  logic        xrd_n     = 1'b1;
  logic        xwr_n     = 1'b1;
  logic [7:0]  sfr_rdata;
  logic [7:0]  pin_level;
  logic [7:0]  pin_o;
  logic [7:0]  pin_oe;
  int          n_mismatch      = 0;
  int          samples_checked = 0;
  localparam logic [7:0] BASE_OFS [8] = '{P4CS_OFS_CS0_LOW, P4CS_OFS_CS0_HIGH,
    P4CS_OFS_CS1_LOW, P4CS_OFS_CS1_HIGH, P4CS_OFS_CS2_LOW, P4CS_OFS_CS2_HIGH,
    P4CS_OFS_CS3_LOW, P4CS_OFS_CS3_HIGH};
  localparam int LOW_BIT [4] = '{0, 1, 2, 8};

  always #5 ref_clk = ~ref_clk;

  p4cs_port dut_u (
    .ref_clk_i   (ref_clk),
    .arst_n_i    (arst_n),
    .sfr_wr_i    (sfr_wr),
    .sfr_rd_i    (sfr_rd),
    .sfr_addr_i  (sfr_addr),
    .sfr_wdata_i (sfr_wdata),
    .sfr_rdata_o (sfr_rdata),
    .xbus_addr_i (xaddr),
    .xbus_rd_n_i (xrd_n),
    .xbus_wr_n_i (xwr_n),
    .pin_i       (pin_level),
    .pin_o       (pin_o),
    .pin_oe_o    (pin_oe)
  );

  p4cs_xperiph periph_u (
    .pin_o_i     (pin_o),
    .pin_oe_i    (pin_oe),
    .pin_level_o (pin_level)
  );

  // *****
  // Shared tasks
  // *****
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_wr    <= 1'b1;
    sfr_addr  <= a;
    sfr_wdata <= d;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sfr_rd   <= 1'b1;
    sfr_addr <= a;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    #1;
    d = sfr_rdata;
  endtask

  task automatic xbus(input logic [15:0] a, input logic rd_n, input logic wr_n);
    @(posedge ref_clk);
    xaddr <= a;
    xrd_n <= rd_n;
    xwr_n <= wr_n;
    @(negedge ref_clk);
  endtask

  function automatic logic [15:0] base_of(input int p);
    return {8'h5a ^ 8'(p), 8'hc3 ^ 8'(p << 4)};
  endfunction

  // *****
  // Scenarios
  // *****
  task automatic t_reset();
    logic [7:0] d;
    chk(pin_o, 8'hff);
    chk(pin_oe, 8'h00);
    for (int i = 0; i < 8; i++) begin
      reg_rd(BASE_OFS[i], d);
      chk(d, 8'h00);
    end
    reg_rd(P4CS_OFS_CONFIG_A, d);
    chk(d, 8'h00);
    reg_rd(P4CS_OFS_POLARITY, d);
    chk(d, 8'h00);
    reg_rd(8'h00, d);
    chk(d, 8'hff);
    reg_rd(P4CS_OFS_DATA, d);
    chk(d, 8'hff);
  endtask

  task automatic t_regs();
    logic [7:0] d;
    reg_wr(P4CS_OFS_POLARITY, 8'hff);
    reg_rd(P4CS_OFS_POLARITY, d);
    chk(d, 8'hfc);
    reg_wr(P4CS_OFS_CONFIG_A, 8'ha5);
    reg_wr(P4CS_OFS_CONFIG_B, 8'h5a);
    reg_wr(8'h01, 8'h33);
    reg_rd(P4CS_OFS_CONFIG_A, d);
    chk(d, 8'ha5);
    reg_rd(P4CS_OFS_CONFIG_B, d);
    chk(d, 8'h5a);
    for (int p = 0; p < 4; p++) begin
      reg_wr(BASE_OFS[2*p], base_of(p)
      [7:0]);
      reg_wr(BASE_OFS[2*p+1], base_of(p)
      [15:8]);
    end
    for (int i = 0; i < 8; i++) begin
      reg_rd(BASE_OFS[i], d);
      chk(d, i[0] ? base_of(i/2)
      [15:8] : base_of(i/2)
      [7:0]);
    end
  endtask

  task automatic t_gpio();
    logic [7:0] d;
    reg_wr(P4CS_OFS_CONFIG_A, 8'h00);
    reg_wr(P4CS_OFS_CONFIG_B, 8'h00);
    reg_wr(P4CS_OFS_DATA, 8'h5a);
    xbus(base_of(0), 1'b0, 1'b0);
    chk({4'h0, pin_o[3:0]}, 8'h0a);
    chk({4'h0, pin_oe[3:0]}, 8'h05);
    repeat (3) @(posedge ref_clk);
    reg_rd(P4CS_OFS_DATA, d);
    chk(d, 8'h5a);
  endtask

  task automatic t_decode();
    logic [15:0] m;
    logic [15:0] w;
    logic [15:0] b;
    for (int p = 0; p < 4; p++) begin
      for (int c = 0; c < 4; c++) begin
        m = 16'hffff << LOW_BIT[c];
        b = base_of(p);
        w = 16'({P4CS_FN_RDWR, 2'(c)}) << (4 * p);
        reg_wr(P4CS_OFS_CONFIG_A, w[7:0]);
        reg_wr(P4CS_OFS_CONFIG_B, w[15:8]);
        reg_wr(P4CS_OFS_POLARITY, 8'h10 << p);
        xbus(b ^ ~m, 1'b0, 1'b1);
        chk({6'h0, pin_oe[p], pin_o[p]}, 8'h03);
        xbus(b ^ (16'h0001 << LOW_BIT[c]), 1'b0, 1'b1);
        chk({6'h0, pin_oe[p], pin_o[p]}, 8'h02);
        xbus(b, 1'b1, 1'b1);
      end
    end
  endtask

  task automatic t_modes();
    logic [1:0] f;
    logic       act;
    logic       exp;
    reg_wr(P4CS_OFS_DATA, 8'hfb);
    reg_wr(P4CS_OFS_POLARITY, 8'h00);
    for (int fi = 0; fi < 4; fi++) begin
      f = 2'(fi);
      reg_wr(P4CS_OFS_CONFIG_B, {4'h0, f, 2'h0});
      for (int k = 0; k < 4; k++) begin
        xbus(k == 3 ? base_of(2) ^ 16'h0001 : base_of(2), k != 1, !(k == 2 || k == 3));
        act = (k == 1 && f[0]) || (k == 2 && f[1]);
        exp = (f == 2'h0) ? 1'b0 : !act;
        chk({7'h0, pin_o[2]}, {7'h0, exp});
      end
    end
  endtask

  // *****
  // Main sequence and hang guard
  // *****
  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset();
    t_regs();
    t_gpio();
    t_decode();
    t_modes();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    summarize();
  end
endmodule
